// [wdt_pkg.sv]
// Purpose: shared constants for the windowed watchdog
// Assumes: 16-bit option word, Avalon-MM byte addresses
// Notes: option word and control register share one field layout
`default_nettype none
package wdt_pkg;
  localparam int OPT_W = 16;
  localparam int CNT_W = 11;
  localparam int ADDR_W = 4;

  // register byte addresses
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] REFRESH_OFS = 4'h4;
  localparam logic [3:0] STATUS_OFS = 4'h8;
  localparam logic [3:0] COUNT_OFS = 4'hc;

  // option word / control register fields
  localparam int OPT_AUTO_BIT = 0;
  localparam int OPT_TMO_LSB = 1;
  localparam int OPT_DIV_LSB = 3;
  localparam int OPT_WEND_LSB = 6;
  localparam int OPT_WSTA_LSB = 9;
  localparam int OPT_NMI_BIT = 12;
  localparam int OPT_LPSTOP_BIT = 13;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // status register fields
  localparam int ST_UNDF_BIT = 0;
  localparam int ST_REFERR_BIT = 1;
  localparam int ST_MODEERR_BIT = 2;
  localparam int ST_RUN_BIT = 3;

  // timeout lengths in prescaled cycles, minus one
  localparam logic [10:0] TMO0_M1 = 11'h07f;
  localparam logic [10:0] TMO1_M1 = 11'h1ff;
  localparam logic [10:0] TMO2_M1 = 11'h3ff;
  localparam logic [10:0] TMO3_M1 = 11'h7ff;

  // prescale ratios minus one
  localparam logic [7:0] DIV1_M1 = 8'h00;
  localparam logic [7:0] DIV16_M1 = 8'h0f;
  localparam logic [7:0] DIV32_M1 = 8'h1f;
  localparam logic [7:0] DIV64_M1 = 8'h3f;
  localparam logic [7:0] DIV128_M1 = 8'h7f;
  localparam logic [7:0] DIV256_M1 = 8'hff;

  typedef enum logic {WD_IDLE = 1'b0, WD_COUNT = 1'b1} wd_state_t;
endpackage
`default_nettype wire

// [windowed_watchdog.sv]
// Purpose: windowed watchdog with prescaler, refresh window and fault fan-out
// Assumes: dedicated watchdog clock sampled as a synchronous level
// Notes: settings latched from the option word during reset
//
// Our own choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none

// Contract
// - underflow or bad refresh fires the response
// - in-window refresh reloads and restarts counter
// - auto-start mode counts right after reset
// - timeout 128, 512, 1024 or 2048 cycles
// - prescale 1, 16, 32, 64, 128, 256
// - window end 0-100 percent, 0 unlimited
// - window start 0-100 percent, 100 unlimited
// - only the selected reset or interrupt fires
// - optional halt during low-power modes
// - interrupt mode also triggers transfer controllers
// - fault event goes to event link
// - debugger halt freezes counter, no faults
// - register-start mode; mismatched start is error
// - watchdog clock fixed, not software changeable
module windowed_watchdog (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [wdt_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [wdt_pkg::OPT_W-1:0] option_setting_word_i,
  input wire logic dedicated_watchdog_clock_i,
  input wire logic low_power_i,
  input wire logic debug_halt_i,
  output logic wdt_reset_o,
  output logic wdt_nmi_o,
  output logic dtc_activation_o,
  output logic elc_event_o
);
  import wdt_pkg::*;

  logic [OPT_W-1:0] opt_reg;
  logic [OPT_W-1:0] ctrl_reg;
  logic [OPT_W-1:0] cfg;
  logic auto_mode;
  wd_state_t state_reg;
  logic start_req_reg;
  logic ack_reg;
  logic req;
  logic wr_en;
  logic clk_prev_reg;
  logic wclk_edge;
  logic [7:0] presc_cnt_reg;
  logic [7:0] div_m1;
  logic [2:0] div_sel;
  logic [10:0] top_m1;
  logic [CNT_W-1:0] cnt_reg;
  logic [11:0] quarter;
  logic [11:0] end_lim;
  logic [11:0] start_lim;
  logic count_en;
  logic tick;
  logic underflow;
  logic refresh_wr;
  logic in_window;
  logic good_refresh;
  logic bad_refresh;
  logic fault;
  logic nmi_mode;
  logic start_wr;
  logic undf_flag_reg;
  logic referr_flag_reg;
  logic modeerr_flag_reg;
  logic [31:0] status_word;

  // settings caught while reset is held
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      opt_reg <= option_setting_word_i;
    end
  end

  assign auto_mode = opt_reg[OPT_AUTO_BIT];
  assign cfg = auto_mode ? opt_reg : ctrl_reg;
  assign nmi_mode = cfg[OPT_NMI_BIT];

  // bus slave: one wait state, writes land on the released edge
  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_reg;
  assign wr_en = avs_write_i & ack_reg;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  assign status_word = {28'h0000000, state_reg == WD_COUNT, modeerr_flag_reg,
                        referr_flag_reg, undf_flag_reg};

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (avs_read_i && !ack_reg) begin
      if (avs_address_i == CTRL_OFS) begin
        avs_readdata_o <= {16'h0000, cfg};
      end else if (avs_address_i == STATUS_OFS) begin
        avs_readdata_o <= status_word;
      end else if (avs_address_i == COUNT_OFS) begin
        avs_readdata_o <= {21'h000000, cnt_reg};
      end else begin
        avs_readdata_o <= 32'h00000000;
      end
    end
  end

  // control register: config is frozen once counting
  assign start_wr = wr_en && avs_address_i == CTRL_OFS && avs_writedata_i[OPT_AUTO_BIT];

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ctrl_reg <= CTRL_RESET;
      start_req_reg <= 1'b0;
    end else begin
      start_req_reg <= 1'b0;
      if (wr_en && avs_address_i == CTRL_OFS && !auto_mode && state_reg == WD_IDLE) begin
        ctrl_reg <= avs_writedata_i[OPT_W-1:0];
        start_req_reg <= avs_writedata_i[OPT_AUTO_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_reg <= WD_IDLE;
    end else begin
      case (state_reg)
        WD_IDLE: begin
          if (auto_mode || start_req_reg) begin
            state_reg <= WD_COUNT;
          end
        end
        default: begin
          state_reg <= WD_COUNT;
        end
      endcase
    end
  end

  // timeout and ratio decode
  always_comb begin
    case (cfg[OPT_TMO_LSB +: 2])
      2'h0: top_m1 = TMO0_M1;
      2'h1: top_m1 = TMO1_M1;
      2'h2: top_m1 = TMO2_M1;
      default: top_m1 = TMO3_M1;
    endcase
  end

  assign div_sel = cfg[OPT_DIV_LSB +: 3];

  always_comb begin
    case (div_sel)
      3'h0: div_m1 = DIV1_M1;
      3'h1: div_m1 = DIV16_M1;
      3'h2: div_m1 = DIV32_M1;
      3'h3: div_m1 = DIV64_M1;
      3'h4: div_m1 = DIV128_M1;
      default: div_m1 = DIV256_M1;
    endcase
  end

  // watchdog clock has no software control, only its own pin
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      clk_prev_reg <= 1'b0;
    end else begin
      clk_prev_reg <= dedicated_watchdog_clock_i;
    end
  end

  assign wclk_edge = dedicated_watchdog_clock_i & ~clk_prev_reg;
  assign count_en = state_reg == WD_COUNT && !debug_halt_i &&
                    !(cfg[OPT_LPSTOP_BIT] && low_power_i);
  assign tick = wclk_edge && count_en && presc_cnt_reg == div_m1;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i || state_reg == WD_IDLE) begin
      presc_cnt_reg <= 8'h00;
    end else if (wclk_edge && count_en) begin
      presc_cnt_reg <= tick ? 8'h00 : presc_cnt_reg + 8'h01;
    end
  end

  // window limits measured on the remaining count
  assign quarter = {1'b0, top_m1} + 12'h001;
  assign end_lim = 12'((quarter >> 2) * cfg[OPT_WEND_LSB +: 3]);
  assign start_lim = 12'((quarter >> 2) * cfg[OPT_WSTA_LSB +: 3]);
  assign in_window = {1'b0, cnt_reg} < start_lim && {1'b0, cnt_reg} >= end_lim;

  assign refresh_wr = wr_en && avs_address_i == REFRESH_OFS && state_reg == WD_COUNT;
  assign good_refresh = refresh_wr && in_window;
  assign bad_refresh = refresh_wr && !in_window && !debug_halt_i;
  assign underflow = tick && cnt_reg == 11'h000;
  assign fault = underflow | bad_refresh;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cnt_reg <= TMO3_M1;
    end else if (state_reg == WD_IDLE || good_refresh || underflow) begin
      cnt_reg <= top_m1;
    end else if (tick) begin
      cnt_reg <= cnt_reg - 11'h001;
    end
  end

  // response outputs: one-cycle pulses
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wdt_reset_o <= 1'b0;
      wdt_nmi_o <= 1'b0;
      dtc_activation_o <= 1'b0;
      elc_event_o <= 1'b0;
    end else begin
      wdt_reset_o <= fault && !nmi_mode;
      wdt_nmi_o <= fault && nmi_mode;
      dtc_activation_o <= fault && nmi_mode;
      elc_event_o <= fault;
    end
  end

  // sticky flags, write one to clear; a new event beats the clear
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      undf_flag_reg <= 1'b0;
      referr_flag_reg <= 1'b0;
      modeerr_flag_reg <= 1'b0;
    end else begin
      if (wr_en && avs_address_i == STATUS_OFS) begin
        undf_flag_reg <= (undf_flag_reg & ~avs_writedata_i[ST_UNDF_BIT]) | underflow;
        referr_flag_reg <= (referr_flag_reg & ~avs_writedata_i[ST_REFERR_BIT]) | bad_refresh;
        modeerr_flag_reg <= modeerr_flag_reg & ~avs_writedata_i[ST_MODEERR_BIT];
      end else begin
        undf_flag_reg <= undf_flag_reg | underflow;
        referr_flag_reg <= referr_flag_reg | bad_refresh;
        modeerr_flag_reg <= modeerr_flag_reg | (start_wr && auto_mode);
      end
    end
  end

  // checks
  property p_fault_resp;
    @(posedge sys_clk_i) disable iff (srst_i)
    underflow && !nmi_mode |=> wdt_reset_o && !wdt_nmi_o;
  endproperty
  a_fault_resp: assert property (p_fault_resp) else $error("underflow gave no reset");

  property p_reload;
    @(posedge sys_clk_i) disable iff (srst_i)
    good_refresh |=> cnt_reg == $past(top_m1) && !wdt_reset_o && !wdt_nmi_o;
  endproperty
  a_reload: assert property (p_reload) else $error("refresh did not reload");

  property p_autostart;
    @(posedge sys_clk_i)
    $fell(srst_i) && opt_reg[OPT_AUTO_BIT] |=> state_reg == WD_COUNT;
  endproperty
  a_autostart: assert property (p_autostart) else $error("auto start missed");

  property p_timeout;
    @(posedge sys_clk_i) disable iff (srst_i)
    state_reg == WD_IDLE && auto_mode && opt_reg[OPT_TMO_LSB +: 2] == 2'h0 |=> cnt_reg == 11'h07f;
  endproperty
  a_timeout: assert property (p_timeout) else $error("wrong timeout load");

  property p_presc;
    @(posedge sys_clk_i) disable iff (srst_i)
    tick && div_sel != 3'h0 |=> !tick [*8];
  endproperty
  a_presc: assert property (p_presc) else $error("prescaler too fast");

  property p_win_end;
    @(posedge sys_clk_i) disable iff (srst_i)
    refresh_wr && !debug_halt_i && {1'b0, cnt_reg} < end_lim |=> wdt_reset_o || wdt_nmi_o;
  endproperty
  a_win_end: assert property (p_win_end) else $error("late refresh accepted");

  property p_win_start;
    @(posedge sys_clk_i) disable iff (srst_i)
    refresh_wr && !debug_halt_i && {1'b0, cnt_reg} >= start_lim |=> wdt_reset_o || wdt_nmi_o;
  endproperty
  a_win_start: assert property (p_win_start) else $error("early refresh accepted");

  property p_lpstop;
    @(posedge sys_clk_i) disable iff (srst_i)
    state_reg == WD_COUNT && low_power_i && cfg[OPT_LPSTOP_BIT] && !refresh_wr |=> $stable(cnt_reg);
  endproperty
  a_lpstop: assert property (p_lpstop) else $error("counted in low power");

  property p_dtc;
    @(posedge sys_clk_i) disable iff (srst_i)
    dtc_activation_o |-> wdt_nmi_o && !wdt_reset_o && elc_event_o;
  endproperty
  a_dtc: assert property (p_dtc) else $error("transfer trigger without nmi");

  property p_elc;
    @(posedge sys_clk_i) disable iff (srst_i)
    fault |=> elc_event_o ##1 !elc_event_o || $past(fault);
  endproperty
  a_elc: assert property (p_elc) else $error("event link missed fault");

  property p_debug;
    @(posedge sys_clk_i) disable iff (srst_i)
    debug_halt_i && !refresh_wr && state_reg == WD_COUNT |=> $stable(cnt_reg) && !wdt_reset_o && !wdt_nmi_o;
  endproperty
  a_debug: assert property (p_debug) else $error("active under debug");

  property p_modeerr;
    @(posedge sys_clk_i) disable iff (srst_i)
    start_wr && auto_mode |=> modeerr_flag_reg;
  endproperty
  a_modeerr: assert property (p_modeerr) else $error("mode error not flagged");

  c_underflow: cover property (@(posedge sys_clk_i) disable iff (srst_i) underflow);
  c_good_refresh: cover property (@(posedge sys_clk_i) disable iff (srst_i) good_refresh);
  c_bad_refresh: cover property (@(posedge sys_clk_i) disable iff (srst_i) bad_refresh);
  c_nmi: cover property (@(posedge sys_clk_i) disable iff (srst_i) wdt_nmi_o);
endmodule

`default_nettype wire

// [windowed_independent_watchdog_tb.sv]
// Purpose: self-checking bench for the windowed watchdog
// Assumes: watchdog clock toggles every system cycle, so one rising watchdog clock edge per two cycles
// Notes: drivers queue expected results, a watcher process compares them
`timescale 1ns/1ns
`default_nettype none
module windowed_independent_watchdog_tb;
  import wdt_pkg::*;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [ADDR_W-1:0] avs_address_i = '0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = '0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [OPT_W-1:0] opt = '0;
  logic wclk = 1'b0;
  logic low_power_i = 1'b0;
  logic debug_halt_i = 1'b0;
  logic wdt_reset_o;
  logic wdt_nmi_o;
  logic dtc_activation_o;
  logic elc_event_o;
  int failures = 0;
  int n_compared = 0;
  logic [31:0] rd_q[$];
  logic [2:0] ev_q[$];

  windowed_watchdog dut_u (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .option_setting_word_i(opt),
    .dedicated_watchdog_clock_i(wclk),
    .low_power_i(low_power_i),
    .debug_halt_i(debug_halt_i),
    .wdt_reset_o(wdt_reset_o),
    .wdt_nmi_o(wdt_nmi_o),
    .dtc_activation_o(dtc_activation_o),
    .elc_event_o(elc_event_o)
  );

  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // fastest rate the level-sampled watchdog clock allows
  always @(posedge sys_clk_i) begin
    wclk <= ~wclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    if (failures == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // any fault pulse with no note queued is itself a mismatch
  always @(posedge sys_clk_i) begin
    if (!srst_i && avs_read_i && avs_waitrequest_o === 1'b0) begin
      if (rd_q.size() == 0) begin
        check("unnoted read", 32'h1, 32'h0);
      end else begin
        check("read data", avs_readdata_o, rd_q.pop_front());
      end
    end
    if (elc_event_o !== 1'b0 || wdt_reset_o !== 1'b0 || wdt_nmi_o !== 1'b0) begin
      if (ev_q.size() == 0) begin
        check("unexpected fault", {29'h0, wdt_reset_o, wdt_nmi_o, elc_event_o}, 32'h0);
      end else begin
        check("fault pulses", {28'h0, elc_event_o, wdt_reset_o, wdt_nmi_o, dtc_activation_o},
              {28'h1, ev_q.pop_front()});
      end
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  // request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    do begin
      @(posedge sys_clk_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 50);
    if (k >= 50) begin
      check("bus timeout", 32'h1, 32'h0);
      close_out();
    end else begin
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      @(posedge sys_clk_i);
    end
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic wait_fault(input int lim);
    int k;
    for (k = 0; k < lim && ev_q.size() != 0; k++) begin
      @(posedge sys_clk_i);
    end
    if (ev_q.size() != 0) begin
      check("fault missing", 32'h1, 32'h0);
      close_out();
    end
  endtask

  task automatic restart(input logic [15:0] o);
    srst_i <= 1'b1;
    opt <= o;
    cyc(3);
    srst_i <= 1'b0;
    cyc(2);
  endtask

  function automatic logic [15:0] optw(input int a, t, d, we, ws, n, l);
    return {2'b00, l[0], n[0], ws[2:0], we[2:0], d[2:0], t[1:0], a[0]};
  endfunction

  initial begin
    int i;
    int p;
    int nn[4] = '{128, 512, 1024, 2048};
    int dv[5] = '{1, 16, 32, 64, 128};
    int tt[8] = '{0, 1, 2, 3, 0, 0, 0, 0};
    int dd[8] = '{0, 0, 0, 0, 1, 2, 3, 4};
    void'($urandom(38537));
    // low power has no effect without the stop option
    low_power_i <= 1'($urandom % 2);
    restart(optw(1, 0, 0, 0, 4, 0, 0));
    rd(CTRL_OFS, {16'h0, optw(1, 0, 0, 0, 4, 0, 0)});
    rd(4'(1 + $urandom % 3), 32'h0);
    cyc(20 + $urandom % 100);
    bus(1'b1, REFRESH_OFS, $urandom);
    cyc(240);
    ev_q.push_back(3'b100);
    wait_fault(40);
    rd(STATUS_OFS, 32'h9);
    bus(1'b1, STATUS_OFS, 32'h1);
    rd(STATUS_OFS, 32'h8);
    bus(1'b1, CTRL_OFS, 32'h1);
    rd(STATUS_OFS, 32'hc);
    rd(CTRL_OFS, {16'h0, optw(1, 0, 0, 0, 4, 0, 0)});
    low_power_i <= 1'b0;
    // window end at half: early refresh fine, late one is a fault
    restart(optw(1, 0, 0, 2, 4, 1, 0));
    bus(1'b1, REFRESH_OFS, 32'h0);
    cyc(170);
    ev_q.push_back(3'b011);
    bus(1'b1, REFRESH_OFS, 32'h0);
    wait_fault(10);
    rd(STATUS_OFS, 32'ha);
    // window start at a quarter, with a debugger halt first
    restart(optw(1, 0, 0, 0, 1, 1, 0));
    debug_halt_i <= 1'b1;
    cyc(300);
    bus(1'b1, REFRESH_OFS, 32'h0);
    cyc(5);
    debug_halt_i <= 1'b0;
    ev_q.push_back(3'b011);
    bus(1'b1, REFRESH_OFS, 32'h0);
    wait_fault(10);
    cyc(205);
    bus(1'b1, REFRESH_OFS, 32'h0);
    cyc(230);
    // stop in low power
    restart(optw(1, 0, 0, 0, 4, 0, 1));
    low_power_i <= 1'b1;
    cyc(400);
    low_power_i <= 1'b0;
    bus(1'b1, REFRESH_OFS, 32'h0);
    cyc(200);
    ev_q.push_back(3'b100);
    wait_fault(80);
    // register start: idle until software starts it
    restart(optw(0, 0, 0, 0, 4, 0, 0));
    cyc(300);
    rd(STATUS_OFS, 32'h0);
    bus(1'b1, CTRL_OFS, {16'h0, optw(1, 0, 0, 0, 4, 0, 0)});
    cyc(245);
    ev_q.push_back(3'b100);
    wait_fault(40);
    // divide by 256: a full timeout is too long, so count one tick only
    restart(optw(1, 0, 5 + $urandom % 3, 0, 4, 0, 0));
    cyc(760);
    rd(COUNT_OFS, 32'h7e);
    // timeouts and the other prescale ratios
    for (i = 0; i < 8; i++) begin
      p = 2 * nn[tt[i]] * dv[dd[i]];
      restart(optw(1, tt[i], dd[i], 0, 4, 0, 0));
      cyc(p - p / 32 - 8);
      ev_q.push_back(3'b100);
      wait_fault(p / 16 + 16);
    end
    close_out();
  end
endmodule
`default_nettype wire
